// [common/lrsc_pkg.sv]
// ****************
// resonant half-bridge shift control: shared definitions
// ****************
package lrsc_pkg;

   // ****************
   // clock and timing
   // ****************
   localparam int unsigned CLK_HZ = 250_000_000; // hclk rate
   localparam int unsigned SS_TIMEOUT_MS = 100; // soft-start limit
   // soft-start limit in hclk cycles (25,000,000)
   localparam int unsigned SS_TIMEOUT_CYCLES =
      (CLK_HZ / 1000) * SS_TIMEOUT_MS;
   localparam int unsigned RESTART_US = 50; // non-latched fault pause
   localparam int unsigned RESTART_CYCLES =
      (CLK_HZ / 1_000_000) * RESTART_US;
   localparam int unsigned CS_DISC_US = 10; // stuck time for disconnect
   localparam int unsigned CS_DISC_CYCLES =
      (CLK_HZ / 1_000_000) * CS_DISC_US;
   localparam int unsigned LONG_W = 25; // long counter width
   localparam int unsigned DISC_W = 12; // disconnect counter width
   localparam int unsigned TMR_W = 11; // gate timer / shift width
   // a crossing seen within the synchroniser lag of a rise is zero
   localparam logic [10:0] ZC_LAT = 11'h003;

   // ****************
   // register byte offsets
   // ****************
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_DEADTIME = 8'h04;
   localparam logic [7:0] OFS_OLP = 8'h08;
   localparam logic [7:0] OFS_HARD_OVERCURRENT_FAULT = 8'h0c;
   localparam logic [7:0] OFS_ACP = 8'h10;
   localparam logic [7:0] OFS_SHIFT = 8'h14;
   localparam logic [7:0] OFS_STATUS = 8'h18;
   localparam logic [7:0] OFS_MEAS = 8'h1c;

   // ****************
   // control register bits
   // ****************
   localparam int unsigned CTRL_EN = 0; // run the converter
   localparam int unsigned CTRL_FB_SD_EN = 1; // feedback shutdown on
   localparam int unsigned CTRL_SOFT_ACP = 2; // soft anti-capacitive
   localparam int unsigned CTRL_HARD_ACP = 3; // hard anti-capacitive
   localparam int unsigned CTRL_OVP_EN = 4; // aux overvoltage on
   localparam int unsigned CTRL_DISC_EN = 5; // cs disconnect on
   localparam int unsigned CTRL_HYST = 6; // 0: 5 mV, 1: 10 mV
   localparam int unsigned CTRL_OLP_LATCH = 8;
   localparam int unsigned CTRL_HARD_OVERCURRENT_FAULT_LATCH = 9;
   localparam int unsigned CTRL_SST_LATCH = 10;
   localparam int unsigned CTRL_OVP_LATCH = 11;

   // ****************
   // fault indices (status and latch vectors)
   // ****************
   localparam int unsigned NFAULT = 7;
   localparam int unsigned F_OLP = 0; // overload_fault
   localparam int unsigned F_HARD_OVERCURRENT_FAULT = 1; // hard_overcurrent_fault
   localparam int unsigned F_SST = 2; // soft-start timeout
   localparam int unsigned F_OVP = 3; // aux overvoltage
   localparam int unsigned F_ACP = 4; // hard anti_capacitive_guard
   localparam int unsigned F_DISC = 5; // current-sense disconnect
   localparam int unsigned F_FB = 6; // feedback shutdown

   // ****************
   // reset values
   // ****************
   localparam logic [15:0] CTRL_RST = 16'h0000;
   localparam logic [7:0] DEADTIME_RST = 8'h10;
   localparam logic [7:0] OLP_THR_RST = 8'h80;
   localparam logic [15:0] OLP_TIME_RST = 16'h0100;
   localparam logic [7:0] HARD_OVERCURRENT_FAULT_LIM_RST = 8'h04;
   localparam logic [7:0] ACP_THR_RST = 8'h08;
   localparam logic [7:0] ACP_STEP_RST = 8'h04;
   localparam logic [10:0] SHIFT_MAX_RST = 11'h200;

   // ****************
   // ahb-lite
   // ****************
   localparam int unsigned HTRANS_ACTIVE = 1; // nonseq or seq
   localparam logic HRESP_OKAY = 1'b0;

   // ****************
   // types
   // ****************
   // comparator flags from the analog front end
   typedef struct packed {
      logic overload; // overload_comparator
      logic hard_current; // hard_current_comparator (700 mV)
      logic zero_cross; // zero_cross_detector level
      logic fb_low; // loop_error_feedback below 125 mV
      logic aux_ovp; // aux_winding_sense above 2.5 V
      logic cs_low; // tank_current_sense stuck at 0 V
      logic cs_high; // tank_current_sense stuck at 5 V
      logic regulated; // output has reached regulation
   } lrsc_cmp_t;

   // gate_event_state_machine states
   typedef enum logic [2:0] {
      G_OFF, G_HS_ON, G_DT_HL, G_LS_ON, G_DT_LH
   } lrsc_gate_t;

   // converter run phase
   typedef enum logic [1:0] {
      RUN_STOP, RUN_SOFT, RUN_REG
   } lrsc_run_t;

endpackage

// [rtl/lrsc_top.sv]
`timescale 1ns/1ps
// Behaviour
// - overload in every period for check time: fault
// - hard current consecutive count trips shutdown
// - zero-cross feeds fsm; hysteresis selectable
// - time-shift derived from feedback ADC code
// - feedback low shuts down, restart soft-start
// - one bit enables feedback shutdown
// - one event-driven gate state machine, coupled halves
// - switching transitions only on zero-cross or timers; run start and stop also move the fsm
// - symmetric shift keeps duty at half
// - shift delays turn-off after zero-cross
// - short rise-to-zero-cross reduces time-shift
// - zero rise-to-zero-cross stops at once
// - soft and hard guards individually enabled
// - overload check time, then shutdown if persists
// - hard overcurrent latch is configurable
// - soft-start timeout fault, latch configurable
// - aux overvoltage fault, latchable, can disable
// - stuck current sense in soft-start latches
module lrsc_top
   import lrsc_pkg::*;
#(
   parameter int unsigned SS_TIMEOUT_CYC = SS_TIMEOUT_CYCLES,
   parameter int unsigned RESTART_CYC = RESTART_CYCLES
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // analog front end
   input wire lrsc_cmp_t cmp_raw,
   input wire logic [9:0] loop_error_feedback,
   output logic zcd_hyst_sel,
   output logic [7:0] overload_threshold,
   // half-bridge gates
   output logic high_side_gate_out,
   output logic low_side_gate_out
);

   // ****************
   // state
   // ****************
   typedef struct packed {
      lrsc_cmp_t sync1; // first synchroniser stage
      lrsc_cmp_t sync2; // second synchroniser stage
      logic zc_prev; // last zero-cross level
      logic [15:0] ctrl; // control bits
      logic [7:0] deadtime; // dead time minus one, in cycles
      logic [7:0] olp_thr; // overload comparator threshold code
      logic [15:0] olp_time; // overload check time in periods
      logic [7:0] hard_overcurrent_fault_lim; // consecutive hard-current periods
      logic [7:0] acp_thr; // soft guard threshold, cycles
      logic [7:0] acp_step; // soft guard shift reduction step
      logic [10:0] shift_max; // upper clamp of time-shift
      logic hsel_d; // data phase pending
      logic hwrite_d; // data phase is a write
      logic [7:0] addr_d; // data phase address
      logic [31:0] rdata; // read data
      lrsc_gate_t gate; // gate fsm state
      lrsc_run_t run; // run phase
      logic [10:0] tmr; // gate timer
      logic zc_seen; // zero-cross seen this half
      logic [10:0] meas; // last rise-to-zero-cross time
      logic [10:0] shift_cyc; // shift held for the whole period
      logic [10:0] acp_red; // soft guard reduction
      logic [10:0] ss_ramp; // soft-start shift ceiling
      logic olp_hit; // overload seen this period
      logic ocp_hit; // hard current seen this period
      logic [15:0] olp_cnt; // periods in overload
      logic [7:0] ocp_cnt; // consecutive hard-current periods
      logic [24:0] ss_cnt; // soft-start elapsed cycles
      logic [11:0] disc_cnt; // stuck current-sense cycles
      logic [24:0] rst_cnt; // restart pause
      logic [6:0] sticky; // fault history, write one to clear
      logic [6:0] latched; // faults held until reset
      logic hs; // high side gate
      logic ls; // low side gate
   } lrsc_state_t;

   lrsc_state_t s; // registered state
   lrsc_state_t next_s; // next state

   // ****************
   // fixed bus answers
   // ****************
   // every transfer completes with no wait state and an okay
   assign hreadyout = 1'b1;
   assign hresp = HRESP_OKAY;
   assign hrdata = s.rdata;
   assign zcd_hyst_sel = s.ctrl[CTRL_HYST];
   assign overload_threshold = s.olp_thr;
   assign high_side_gate_out = s.hs;
   assign low_side_gate_out = s.ls;

   // ****************
   // register read mux
   // ****************
   function automatic logic [31:0] read_reg(input lrsc_state_t st,
                                            input logic [7:0] a);
      logic [31:0] v;
      v = 32'h0000_0000;
      unique case (a)
         OFS_CTRL: v = {16'h0000, st.ctrl};
         OFS_DEADTIME: v = {24'h00_0000, st.deadtime};
         OFS_OLP: v = {8'h00, st.olp_thr, st.olp_time};
         OFS_HARD_OVERCURRENT_FAULT: v = {24'h00_0000, st.hard_overcurrent_fault_lim};
         OFS_ACP: v = {16'h0000, st.acp_step, st.acp_thr};
         OFS_SHIFT: v = {21'h00_0000, st.shift_max};
         OFS_STATUS: v = {17'h0_0000, st.latched, 1'b0, st.sticky};
         OFS_MEAS: v = {3'(st.gate), 2'(st.run), st.meas, 5'h00,
                        st.shift_cyc};
         default: v = 32'h0000_0000; // unmapped reads as zero
      endcase
      return v;
   endfunction

   // ****************
   // next-state logic
   // ****************
   always_comb begin
      lrsc_cmp_t c;
      logic zc_evt;
      logic addr_ok;
      logic [6:0] clr;
      logic [6:0] fset;
      logic [6:0] lmask;
      logic stop;
      logic on_st;
      logic period_start;
      logic [10:0] tgt;
      logic [10:0] sh;
      logic [10:0] dt;
      logic [11:0] red_sum;
      c = s.sync2;
      zc_evt = 1'b0;
      addr_ok = 1'b0;
      clr = 7'h00;
      fset = 7'h00;
      lmask = 7'h00;
      stop = 1'b0;
      on_st = 1'b0;
      period_start = 1'b0;
      tgt = 11'h000;
      sh = 11'h000;
      dt = 11'h000;
      red_sum = 12'h000;
      next_s = s;

      // two-stage synchroniser for every comparator flag
      next_s.sync1 = cmp_raw;
      next_s.sync2 = s.sync1;

      zc_evt = c.zero_cross ^ s.zc_prev;
      next_s.zc_prev = c.zero_cross;

      // ---------------- bus data phase: writes ----------------
      if (s.hsel_d && s.hwrite_d) begin
         unique case (s.addr_d)
            OFS_CTRL: next_s.ctrl = hwdata[15:0];
            OFS_DEADTIME: next_s.deadtime = hwdata[7:0];
            OFS_OLP: begin
               next_s.olp_time = hwdata[15:0];
               next_s.olp_thr = hwdata[23:16];
            end
            OFS_HARD_OVERCURRENT_FAULT: next_s.hard_overcurrent_fault_lim = hwdata[7:0];
            OFS_ACP: begin
               next_s.acp_thr = hwdata[7:0];
               next_s.acp_step = hwdata[15:8];
            end
            OFS_SHIFT: next_s.shift_max = hwdata[10:0];
            OFS_STATUS: clr = hwdata[6:0];
            default: ; // unmapped or read-only: ignored
         endcase
      end

      // ---------------- bus address phase ----------------
      // read data is fetched here so it leaves from a flop
      addr_ok = hsel && hready && htrans[HTRANS_ACTIVE];
      next_s.hsel_d = addr_ok;
      next_s.hwrite_d = hwrite;
      next_s.addr_d = {haddr[7:2], 2'b00};
      if (addr_ok && !hwrite) begin
         next_s.rdata = read_reg(s, {haddr[7:2], 2'b00});
      end

      // ---------------- time-shift target ----------------
      // shift from feedback code, clamped
      tgt = ({1'b0, loop_error_feedback} > s.shift_max) ?
            s.shift_max : {1'b0, loop_error_feedback};
      // soft-start lets the shift grow one step per period
      if (s.run == RUN_SOFT && s.ss_ramp < tgt) begin
         tgt = s.ss_ramp;
      end
      sh = (tgt > s.acp_red) ? tgt - s.acp_red : 11'h000;
      dt = {3'b000, s.deadtime};

      // ---------------- level faults ----------------
      // aux overvoltage, can be disabled
      fset[F_OVP] = s.ctrl[CTRL_OVP_EN] && c.aux_ovp;
      fset[F_FB] = s.ctrl[CTRL_FB_SD_EN] && c.fb_low;

      if (s.run == RUN_SOFT && s.ctrl[CTRL_DISC_EN] &&
          (c.cs_low || c.cs_high)) begin
         next_s.disc_cnt = s.disc_cnt + 12'h001;
         fset[F_DISC] = (s.disc_cnt >= DISC_W'(CS_DISC_CYCLES - 1));
      end else begin
         next_s.disc_cnt = 12'h000;
      end

      if (s.run == RUN_SOFT) begin
         next_s.ss_cnt = s.ss_cnt + 25'h000_0001;
         if (c.regulated) begin
            next_s.run = RUN_REG;
         end else if (s.ss_cnt >= LONG_W'(SS_TIMEOUT_CYC - 1)) begin
            fset[F_SST] = 1'b1;
         end
      end

      // ---------------- per-period current checks ----------------
      if (s.gate != G_OFF) begin
         if (c.overload) begin
            next_s.olp_hit = 1'b1;
         end
         if (c.hard_current) begin
            next_s.ocp_hit = 1'b1;
         end
      end

      // ---------------- gate event state machine ----------------
      // coupled high/low halves
      on_st = (s.gate == G_HS_ON) || (s.gate == G_LS_ON);
      unique case (s.gate)
         G_OFF: begin
            next_s.tmr = 11'h000;
         end
         G_DT_LH, G_DT_HL: begin
            next_s.tmr = s.tmr + 11'h001;
            if (s.tmr >= dt) begin
               next_s.tmr = 11'h000;
               next_s.zc_seen = 1'b0;
               next_s.gate = (s.gate == G_DT_LH) ? G_HS_ON : G_LS_ON;
               period_start = (s.gate == G_DT_LH);
            end
         end
         G_HS_ON, G_LS_ON: begin
            if (!s.zc_seen) begin
               // measuring gate rise to zero-cross
               if (s.tmr != {TMR_W{1'b1}}) begin
                  next_s.tmr = s.tmr + 11'h001;
               end
               if (zc_evt) begin
                  next_s.zc_seen = 1'b1;
                  next_s.meas = s.tmr;
                  next_s.tmr = 11'h000;
                  fset[F_ACP] = s.ctrl[CTRL_HARD_ACP] &&
                                (s.tmr <= ZC_LAT);
                  if (s.ctrl[CTRL_SOFT_ACP] &&
                      s.tmr < {3'b000, s.acp_thr}) begin
                     red_sum = {1'b0, s.acp_red} +
                               {4'h0, s.acp_step};
                     next_s.acp_red = red_sum[11] ?
                        {TMR_W{1'b1}} : red_sum[10:0];
                  end
               end
            end else begin
               next_s.tmr = s.tmr + 11'h001;
               if (s.tmr >= s.shift_cyc) begin
                  next_s.tmr = 11'h000;
                  next_s.gate = (s.gate == G_HS_ON) ? G_DT_HL : G_DT_LH;
               end
            end
         end
      endcase

      // ---------------- period boundary ----------------
      if (period_start) begin
         next_s.shift_cyc = sh;
         if (s.ss_ramp != {TMR_W{1'b1}}) begin
            next_s.ss_ramp = s.ss_ramp + 11'h001;
         end
         // soft guard relaxes slowly when the margin returns
         if (s.acp_red != 11'h000 && next_s.acp_red == s.acp_red) begin
            next_s.acp_red = s.acp_red - 11'h001;
         end
         if (s.olp_hit) begin
            next_s.olp_cnt = s.olp_cnt + 16'h0001;
            fset[F_OLP] = (next_s.olp_cnt >= s.olp_time);
         end else begin
            next_s.olp_cnt = 16'h0000;
         end
         if (s.ocp_hit) begin
            next_s.ocp_cnt = s.ocp_cnt + 8'h01;
            fset[F_HARD_OVERCURRENT_FAULT] = (next_s.ocp_cnt >= s.hard_overcurrent_fault_lim);
         end else begin
            next_s.ocp_cnt = 8'h00;
         end
         next_s.olp_hit = 1'b0;
         next_s.ocp_hit = 1'b0;
      end

      // ---------------- fault bookkeeping ----------------
      // latch selection
      lmask[F_OLP] = s.ctrl[CTRL_OLP_LATCH];
      lmask[F_HARD_OVERCURRENT_FAULT] = s.ctrl[CTRL_HARD_OVERCURRENT_FAULT_LATCH];
      lmask[F_SST] = s.ctrl[CTRL_SST_LATCH];
      lmask[F_OVP] = s.ctrl[CTRL_OVP_LATCH];
      lmask[F_DISC] = 1'b1;
      // a fault arriving with a clear still shows: set wins
      next_s.sticky = (s.sticky & ~clr) | fset;
      next_s.latched = s.latched | (fset & lmask);

      // non-latched event faults pause then restart
      if (|(fset & ~lmask)) begin
         next_s.rst_cnt = LONG_W'(RESTART_CYC);
      end else if (s.rst_cnt != 25'h000_0000) begin
         next_s.rst_cnt = s.rst_cnt - 25'h000_0001;
      end

      stop = (|fset) || (|s.latched) || (s.rst_cnt != 25'h000_0000) ||
             !s.ctrl[CTRL_EN];

      // ---------------- run control ----------------
      if (stop) begin
         next_s.gate = G_OFF;
         next_s.run = RUN_STOP;
         next_s.tmr = 11'h000;
         next_s.olp_hit = 1'b0;
         next_s.ocp_hit = 1'b0;
         next_s.olp_cnt = 16'h0000;
         next_s.ocp_cnt = 8'h00;
      end else if (s.run == RUN_STOP) begin
         next_s.run = RUN_SOFT;
         next_s.gate = G_DT_LH;
         next_s.tmr = 11'h000;
         next_s.ss_cnt = 25'h000_0000;
         next_s.ss_ramp = 11'h000;
         next_s.acp_red = 11'h000;
         next_s.shift_cyc = 11'h000;
      end

      next_s.hs = (next_s.gate == G_HS_ON);
      next_s.ls = (next_s.gate == G_LS_ON);
   end

   // ****************
   // state register
   // ****************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s <= '0;
         s.ctrl <= CTRL_RST;
         s.deadtime <= DEADTIME_RST;
         s.olp_thr <= OLP_THR_RST;
         s.olp_time <= OLP_TIME_RST;
         s.hard_overcurrent_fault_lim <= HARD_OVERCURRENT_FAULT_LIM_RST;
         s.acp_thr <= ACP_THR_RST;
         s.acp_step <= ACP_STEP_RST;
         s.shift_max <= SHIFT_MAX_RST;
         s.gate <= G_OFF;
         s.run <= RUN_STOP;
      end else begin
         s <= next_s;
      end
   end

endmodule

// [verification/lrsc_checker.sv]
`timescale 1ns/1ps
// ****************
// gate and bus checker
// ****************
module lrsc_checker
   import lrsc_pkg::*;
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // register bus
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   // front end and gates
   input wire lrsc_cmp_t cmp_raw,
   input wire logic zcd_hyst_sel,
   input wire logic high_side_gate_out,
   input wire logic low_side_gate_out
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   wire hs = high_side_gate_out; // short alias
   wire ls = low_side_gate_out; // short alias
   wire take = hsel && hready && htrans[1] && hwrite; // write taken
   logic [1:0] wr; // data phase pending: [0] control, [1] dead time
   logic [15:0] ctrl; // shadow of the control word
   logic [8:0] dt; // shadow dead time plus one
   logic [8:0] gap; // samples with both gates low
   // shadows follow bus writes so gating is judged from pins alone
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr <= 2'h0;
         ctrl <= CTRL_RST;
         dt <= {1'b0, DEADTIME_RST} + 9'h001;
         gap <= 9'h000;
      end else begin
         wr <= {take && haddr[7:2] == 6'h01, take && haddr[7:2] == 6'h00};
         if (wr[0])
            ctrl <= hwdata[15:0];
         if (wr[1])
            dt <= {1'b0, hwdata[7:0]} + 9'h001;
         // saturate: a long idle stretch must not wrap to zero
         if (hs || ls)
            gap <= 9'h000;
         else if (gap != 9'h1ff)
            gap <= gap + 9'h001;
      end
   end
   chk_gates_apart: assert property (!(hs && ls))
      else $error("both gates on together");
   chk_no_handover: assert property ($fell(hs) || $fell(ls) |-> !hs && !ls)
      else $error("gate handed over with no gap");
   chk_dead_gap: assert property ($rose(hs) || $rose(ls) |-> gap >= dt)
      else $error("dead time too short");
   chk_run_gated: assert property ((!ctrl[CTRL_EN]) [*3] |-> !hs && !ls)
      else $error("gate on while disabled");
   chk_fb_stop: assert property (
      (ctrl[CTRL_FB_SD_EN] && cmp_raw.fb_low) [*6] |-> !hs && !ls)
      else $error("gate on with feedback low");
   chk_ovp_stop: assert property (
      (ctrl[CTRL_OVP_EN] && cmp_raw.aux_ovp) [*6] |-> !hs && !ls)
      else $error("gate on during overvoltage");
   chk_hyst_sel: assert property (
      $changed(ctrl[CTRL_HYST]) |-> ##[0:1] zcd_hyst_sel == ctrl[CTRL_HYST])
      else $error("hysteresis select stale");
   chk_bus_okay: assert property (hreadyout && hresp == HRESP_OKAY)
      else $error("bus stalled or not okay");
endmodule

bind lrsc_top lrsc_checker u_chk (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
   .hreadyout(hreadyout), .hresp(hresp), .cmp_raw(cmp_raw),
   .zcd_hyst_sel(zcd_hyst_sel), .high_side_gate_out(high_side_gate_out),
   .low_side_gate_out(low_side_gate_out)
);

// [verification/lrsc_tank_model.sv]
`timescale 1ns/1ps
// ****************
// tank sensing model: current reverses after each turn-on
// ****************
module lrsc_tank_model
   import lrsc_pkg::*;
(
   // clock
   input wire logic hclk,
   // bridge gates
   input wire logic high_side_gate_out,
   input wire logic low_side_gate_out,
   // scenario knobs
   input wire logic [7:0] zc_delay,
   input wire lrsc_cmp_t flags,
   // comparator flags to the block
   output lrsc_cmp_t cmp_raw
);
   logic zc = 1'b0; // current polarity
   logic [7:0] cnt = 8'h00; // cycles since turn-on, 0 idle
   logic [1:0] seen = 2'h0; // gates at the previous edge
   wire rise = (high_side_gate_out && !seen[1]) ||
      (low_side_gate_out && !seen[0]);
   // crossing a fixed time after turn-on; zero means at once
   always @(posedge hclk) begin
      seen <= {high_side_gate_out, low_side_gate_out};
      if (rise) begin
         cnt <= (zc_delay == 8'h00) ? 8'h00 : 8'h01;
         if (zc_delay == 8'h00)
            zc <= !zc;
      end else if (cnt != 8'h00) begin
         cnt <= (cnt == zc_delay) ? 8'h00 : cnt + 8'h01;
         if (cnt == zc_delay)
            zc <= !zc;
      end
   end
   // crossing level rides with the scenario flags
   always_comb begin
      cmp_raw = flags;
      cmp_raw.zero_cross = zc;
   end
endmodule

// [verification/tb.sv]
`timescale 1ns/1ps
module tb;
   import lrsc_pkg::*;
   // ****************
   // stimulus and observed signals
   // ****************
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [7:0] zc_delay = 8'h14; // crossing delay after turn-on
   lrsc_cmp_t flags = 8'h01; // healthy: regulated only
   wire hready, hresp, hyst, hs, ls;
   wire [31:0] hrdata;
   wire [7:0] olp_thr;
   lrsc_cmp_t cmp_raw;
   int num_errors = 0;
   int total_checks = 0;
   logic [7:0] ofs [7] = '{OFS_CTRL, OFS_DEADTIME, OFS_OLP, OFS_HARD_OVERCURRENT_FAULT,
      OFS_ACP, OFS_SHIFT, 8'h20};
   logic [31:0] rst [7] = '{{16'h0, CTRL_RST}, {24'h0, DEADTIME_RST},
      {8'h0, OLP_THR_RST, OLP_TIME_RST}, {24'h0, HARD_OVERCURRENT_FAULT_LIM_RST},
      {16'h0, ACP_STEP_RST, ACP_THR_RST}, {21'h0, SHIFT_MAX_RST}, 32'h0};
   always #2 hclk = ~hclk;
   // short timeouts keep the run brief
   lrsc_top #(.SS_TIMEOUT_CYC(4000), .RESTART_CYC(20)) DUT (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hready), .hreadyout(hready), .hresp(hresp),
      .hrdata(hrdata), .cmp_raw(cmp_raw), .loop_error_feedback(10'h080),
      .zcd_hyst_sel(hyst), .overload_threshold(olp_thr),
      .high_side_gate_out(hs), .low_side_gate_out(ls));
   lrsc_tank_model u_tank (.hclk(hclk), .high_side_gate_out(hs),
      .low_side_gate_out(ls), .zc_delay(zc_delay), .flags(flags),
      .cmp_raw(cmp_raw));
   // ****************
   // tasks
   // ****************
   task automatic check(input string what, input logic [31:0] exp,
         input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   // one single transfer; entered just after a rising edge
   task automatic bus(input logic wr, input logic [7:0] a,
         input logic [31:0] wd, output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   task automatic do_reset();
      hresetn <= 1'b0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
   endtask
   // counts samples while the gate pair holds one pattern
   task automatic hold_len(input logic [1:0] v, output int n);
      n = 0;
      while ({hs, ls} === v && n < 5000) begin
         n++;
         @(posedge hclk);
      end
   endtask
   task automatic gate_on(input int n, output int on);
      on = 0;
      repeat (n) begin
         @(posedge hclk);
         if (hs === 1'b1 || ls === 1'b1)
            on++;
      end
   endtask
   // fault case: run, judge gates and status, clear, judge again
   task automatic run_case(input logic [15:0] c, input lrsc_cmp_t f,
         input logic [7:0] zd, input int hold, input logic stops,
         input logic lat, input logic [15:0] m);
      int on;
      logic [31:0] rd;
      do_reset();
      flags <= f;
      zc_delay <= zd;
      bus(1'b1, OFS_DEADTIME, 32'h0, rd);
      bus(1'b1, OFS_OLP, 32'h0080_0004, rd);
      bus(1'b1, OFS_CTRL, {16'h0, c}, rd);
      repeat (hold) @(posedge hclk);
      gate_on(300, on);
      if (stops !== 1'bx)
         check("gates running", {31'h0, !stops}, {31'h0, on > 150});
      bus(1'b0, OFS_STATUS, 32'h0, rd);
      check("fault status", {16'h0, m}, rd & {16'h0, m});
      flags <= 8'h01;
      zc_delay <= 8'h14;
      repeat (100) @(posedge hclk);
      gate_on(300, on);
      check("gates after clear", {31'h0, !lat}, {31'h0, on > 150});
      $display("case %h done", c);
   endtask
   task automatic print_verdict();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // ****************
   // tests
   // ****************
   initial begin
      logic [31:0] rd;
      int a, g, b;
      do_reset();
      bus(1'b1, 8'h20, 32'hffff_ffff, rd);
      for (int i = 0; i < 7; i++) begin
         bus(1'b0, ofs[i], 32'h0, rd);
         check("reset value", rst[i], rd);
      end
      bus(1'b1, OFS_OLP, 32'h005a_0100, rd);
      bus(1'b1, OFS_CTRL, 32'h40, rd);
      bus(1'b0, OFS_CTRL, 32'h0, rd);
      check("control", 32'h40, rd);
      check("hysteresis select", 32'h1, {31'h0, hyst});
      check("overload threshold", 32'h5a, {24'h0, olp_thr});
      $display("registers done");
      do_reset();
      bus(1'b1, OFS_DEADTIME, 32'h5, rd);
      bus(1'b1, OFS_CTRL, 32'h1, rd);
      repeat (800) @(posedge hclk);
      a = 0;
      while (ls !== 1'b1 && a < 3000) begin
         @(posedge hclk);
         a++;
      end
      hold_len(2'b01, a);
      hold_len(2'b00, a);
      hold_len(2'b10, a);
      hold_len(2'b00, g);
      hold_len(2'b01, b);
      check("low on time", a, b);
      check("dead time", 32'h6, g);
      check("on past crossing", 32'h1, {31'h0, a > 20});
      $display("switching done");
      run_case(16'h0003, 8'h11, 8'h14, 50, 1, 0, 16'h0040);
      run_case(16'h0001, 8'h11, 8'h14, 50, 0, 0, 16'h0000);
      run_case(16'h0811, 8'h09, 8'h14, 50, 1, 1, 16'h0808);
      run_case(16'h0801, 8'h09, 8'h14, 50, 0, 0, 16'h0000);
      run_case(16'h0009, 8'h01, 8'h00, 300, 1, 0, 16'h0010);
      run_case(16'h0001, 8'h01, 8'h00, 300, 0, 0, 16'h0000);
      run_case(16'h0201, 8'h41, 8'h14, 1000, 1, 1, 16'h0202);
      run_case(16'h0001, 8'h41, 8'h14, 1000, 1'bx, 0, 16'h0002);
      run_case(16'h0101, 8'h81, 8'h14, 1000, 1, 1, 16'h0101);
      run_case(16'h0401, 8'h00, 8'h14, 4200, 1, 1, 16'h0404);
      run_case(16'h0021, 8'h04, 8'h14, 2700, 1, 1, 16'h2020);
      run_case(16'h0001, 8'h04, 8'h14, 2700, 0, 0, 16'h0000);
      print_verdict();
   end
   // watchdog: the tests need about a quarter of this span
   initial begin
      repeat (100000) @(posedge hclk);
      num_errors++;
      $display("BAD watchdog expected finish seen timeout");
      print_verdict();
   end
endmodule
